//--- rtl/port_power_config_regs.v
// Contract
// - Custom-handshake switch enable is sampled only when emulation starts.
// - Custom enable closes data switch during custom profile and after its acceptance.
// - Every emulation restart closes the high-speed data switch.
// - CDP enable, sampled at emulation start, closes or opens switch in CDP handshake.
// - In Detect state detect enable sets switch; ignored when detection control is 0.
// - Accepted-profile enable closes switch only in Active after DCP/legacy acceptance.
// - Three-bit current limit code maps 0.57A up to 2.85A in eight steps.
// - Default limit from strap; software limit never exceeds the strapped value.
// - On each total update, total at or above threshold sets the rationing flag.
// - Sixteen-bit threshold, high byte 1Ah, low byte 1Bh, both reset FFh.
// - Recovery applies test current, turns switch on, times, checks bus voltage.
// - Recovery start delay waits 15 to 50 ms per code after error entry.
// - Recovery test time is 10, 15, 20 or 25 ms by code.
// - Recovery test voltage is 250, 500, 750 or 1000 mV by code.
// - Emulation succeeds when bus current exceeds the charging current threshold.
// - Four-bit charging current threshold resets to all ones, 11.72 mA steps.
// - Charging current threshold is lost in Sleep and returns to reset value.
// - Switch, limit, threshold and recovery registers are kept through Sleep.
`timescale 1ns/1ps
`default_nettype none
`include "port_power_config_map.vh"

module port_power_config_regs (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  // Register port from the serial interface
  input  wire [7:0]  reg_addr_i,
  input  wire [7:0]  reg_wdata_i,
  input  wire        reg_wr_i,
  output reg  [7:0]  reg_rdata_o,
  // Power state and emulation status
  input  wire        sleep_i,
  input  wire        active_state_i,
  input  wire        detect_state_i,
  input  wire        detection_control_i,
  input  wire        emulation_start_i,
  input  wire [1:0]  emulation_profile_i,
  input  wire        profile_accepted_i,
  input  wire        charging_i,
  // Current limit strap and measurements
  input  wire [2:0]  strap_limit_code_i,
  input  wire        total_update_i,
  input  wire [15:0] total_charge_i,
  input  wire [3:0]  bus_current_code_i,
  input  wire        error_entry_i,
  input  wire        overtemp_ok_i,
  input  wire        backdrive_ok_i,
  input  wire [1:0]  bus_voltage_code_i,
  input  wire        bus_below_test_i,
  input  wire        reached_flag_a_clear_i,
  // Outputs to analog/control
  output reg         data_switch_close_o,
  output wire [2:0]  switch_current_limit_o,
  output wire [15:0] reached_flag_a_threshold_value_o,
  output reg         reached_flag_a_o,
  output reg         reached_flag_a_event_o,
  output wire [3:0]  charge_detect_current_o,
  output reg         emulation_success_o,
  output wire [1:0]  recovery_test_level_o,
  output reg         recovery_test_current_o,
  output reg         recovery_port_on_o,
  output reg         recovery_short_o
);

  // Fault recovery states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_TEST = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg  [2:0]  port_current_limit_reg;
  reg  [7:0]  reached_flag_a_high_reg;
  reg  [7:0]  reached_flag_a_low_reg;
  reg  [6:0]  fault_recovery_reg;
  reg  [3:0]  charge_threshold_reg;
  reg  [4:0]  data_switch_reg;
  reg  [2:0]  strap_limit_reg;
  reg         strap_taken_reg;
  reg         custom_en_reg;
  reg         cdp_en_reg;
  reg  [3:0]  state_reg;
  reg  [3:0]  state_next;
  reg  [21:0] timer_reg;
  reg  [21:0] timer_next;
  reg  [21:0] delay_cycles;
  reg  [21:0] test_cycles;
  reg  [2:0]  limit_write;
  reg         reached_flag_a_hit;
  reg         switch_next;
  reg  [7:0]  rdata_next;

  wire [2:0] delay_code = fault_recovery_reg[`FRC_DELAY_LSB +: 3];
  wire [1:0] time_code  = fault_recovery_reg[`FRC_TIME_LSB +: 2];

  // One write strobe per register; unmapped offsets strobe nothing
  wire       wr_limit    = reg_wr_i && (reg_addr_i == `ADDR_PORT_CURRENT_LIMIT);
  wire       wr_thr_high = reg_wr_i && (reg_addr_i == `ADDR_REACHED_FLAG_A_THRESHOLD_HIGH);
  wire       wr_thr_low  = reg_wr_i && (reg_addr_i == `ADDR_REACHED_FLAG_A_THRESHOLD_LOW);
  wire       wr_recovery = reg_wr_i && (reg_addr_i == `ADDR_FAULT_RECOVERY_CONFIG);
  wire       wr_charge   = reg_wr_i && (reg_addr_i == `ADDR_CHARGE_CURRENT_THRESH);
  wire       wr_switch   = reg_wr_i && (reg_addr_i == `ADDR_DATA_SWITCH_CONFIG);

  assign switch_current_limit_o   = port_current_limit_reg;
  assign reached_flag_a_threshold_value_o = {reached_flag_a_high_reg, reached_flag_a_low_reg};
  assign charge_detect_current_o  = charge_threshold_reg;
  assign recovery_test_level_o    = fault_recovery_reg[`FRC_VOLT_LSB +: 2];

  // Software limit clamped at the strapped ceiling; codes are monotonic in current
  always @* begin
    limit_write = reg_wdata_i[2:0];
    if (limit_write > strap_limit_reg) begin
      limit_write = strap_limit_reg;
    end
  end

  // Strap captured after reset release, not inside the reset branch
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      strap_taken_reg <= 1'b0;
      strap_limit_reg <= 3'h7;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_limit_reg <= strap_limit_code_i;
    end
  end

  // Register writes; sleep wipes only the charging threshold
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      port_current_limit_reg <= `RST_PORT_CURRENT_LIMIT;
      reached_flag_a_high_reg        <= `RST_REACHED_FLAG_A_THRESHOLD_BYTE;
      reached_flag_a_low_reg         <= `RST_REACHED_FLAG_A_THRESHOLD_BYTE;
      fault_recovery_reg     <= `RST_FAULT_RECOVERY_CONFIG;
      charge_threshold_reg   <= `RST_CHARGE_CURRENT_THRESH;
      data_switch_reg        <= `RST_DATA_SWITCH_CONFIG;
    end else begin
      if (!strap_taken_reg) begin
        port_current_limit_reg <= strap_limit_code_i;
      end else if (wr_limit) begin
        port_current_limit_reg <= limit_write;
      end
      if (wr_thr_high) begin
        reached_flag_a_high_reg <= reg_wdata_i;
      end
      if (wr_thr_low) begin
        reached_flag_a_low_reg <= reg_wdata_i;
      end
      if (wr_recovery) begin
        fault_recovery_reg <= reg_wdata_i[6:0];
      end
      if (sleep_i) begin
        charge_threshold_reg <= `RST_CHARGE_CURRENT_THRESH;
      end else if (wr_charge) begin
        charge_threshold_reg <= reg_wdata_i[3:0];
      end
      // Reserved bit 4 kept at its reset value
      if (wr_switch) begin
        data_switch_reg <= {data_switch_reg[4], reg_wdata_i[3:0]};
      end
      // Other registers untouched by sleep
    end
  end

  // Read mux; unmapped offsets read zero
  always @* begin
    case (reg_addr_i)
      `ADDR_PORT_CURRENT_LIMIT:    rdata_next = {5'h00, port_current_limit_reg};
      `ADDR_REACHED_FLAG_A_THRESHOLD_HIGH: rdata_next = reached_flag_a_high_reg;
      `ADDR_REACHED_FLAG_A_THRESHOLD_LOW:  rdata_next = reached_flag_a_low_reg;
      `ADDR_FAULT_RECOVERY_CONFIG: rdata_next = {1'b0, fault_recovery_reg};
      `ADDR_CHARGE_CURRENT_THRESH: rdata_next = {4'h0, charge_threshold_reg};
      `ADDR_DATA_SWITCH_CONFIG:    rdata_next = {3'h0, data_switch_reg};
      default:                     rdata_next = 8'h00;
    endcase
  end

  // Read data from a flip-flop, one cycle behind the address
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= rdata_next;
    end
  end

  // Handshake enables latched at emulation start only
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      custom_en_reg <= 1'b0;
      cdp_en_reg    <= 1'b1;
    end else if (emulation_start_i) begin
      custom_en_reg <= data_switch_reg[`DSW_CUSTOM_BIT];
      cdp_en_reg    <= data_switch_reg[`DSW_CDP_BIT];
    end
  end

  // Data switch decision; start/restart closes it first
  always @* begin
    switch_next = 1'b0;
    if (emulation_start_i) begin
      switch_next = 1'b1;
    end else if (detect_state_i) begin
      switch_next = detection_control_i & data_switch_reg[`DSW_DETECT_BIT];
    end else if (active_state_i) begin
      case (emulation_profile_i)
        `PROFILE_CDP:    switch_next = cdp_en_reg;
        `PROFILE_CUSTOM: switch_next = custom_en_reg;
        `PROFILE_DCP_LEGACY: begin
          // Never during the applied profile, only once accepted and charging
          switch_next = profile_accepted_i & charging_i
                        & data_switch_reg[`DSW_ACCEPTED_BIT];
        end
        default:         switch_next = 1'b1;
      endcase
    end
  end

  // Switch registered so a profile change never glitches the data lines
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      data_switch_close_o <= 1'b0;
    end else begin
      data_switch_close_o <= switch_next;
    end
  end

  // Success needs strictly more current than the threshold; equal is not enough
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      emulation_success_o <= 1'b0;
    end else begin
      emulation_success_o <= (bus_current_code_i > charge_threshold_reg);
    end
  end

  // Rationing compare, only on a total update
  always @* begin
    reached_flag_a_hit = total_update_i && (total_charge_i >= {reached_flag_a_high_reg, reached_flag_a_low_reg});
  end

  // Event pulse triggers the rationing action outside this block
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      reached_flag_a_event_o <= 1'b0;
    end else begin
      reached_flag_a_event_o <= reached_flag_a_hit;
    end
  end

  // Sticky flag; a new hit wins over a same-cycle clear so no hit is lost
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      reached_flag_a_o <= 1'b0;
    end else if (reached_flag_a_hit) begin
      reached_flag_a_o <= 1'b1;
    end else if (reached_flag_a_clear_i) begin
      reached_flag_a_o <= 1'b0;
    end
  end

  // Start delay in cycles; tens of milliseconds, so long runs to reach
  always @* begin
    case (delay_code)
      3'h0:    delay_cycles = 22'd15 * `MS_CYCLES;
      3'h1:    delay_cycles = 22'd20 * `MS_CYCLES;
      3'h2:    delay_cycles = 22'd25 * `MS_CYCLES;
      3'h3:    delay_cycles = 22'd30 * `MS_CYCLES;
      3'h4:    delay_cycles = 22'd35 * `MS_CYCLES;
      3'h5:    delay_cycles = 22'd40 * `MS_CYCLES;
      3'h6:    delay_cycles = 22'd45 * `MS_CYCLES;
      default: delay_cycles = 22'd50 * `MS_CYCLES;
    endcase
  end

  // Test phase length, loaded when the test starts
  always @* begin
    case (time_code)
      2'h0:    test_cycles = 22'd10 * `MS_CYCLES;
      2'h1:    test_cycles = 22'd15 * `MS_CYCLES;
      2'h2:    test_cycles = 22'd20 * `MS_CYCLES;
      default: test_cycles = 22'd25 * `MS_CYCLES;
    endcase
  end

  // Recovery sequencer: wait, check, test, judge
  always @* begin
    state_next = state_reg;
    timer_next = timer_reg;
    case (state_reg)
      ST_IDLE: begin
        if (error_entry_i) begin
          state_next = ST_WAIT;
          timer_next = delay_cycles - 22'd1;
        end
      end
      ST_WAIT: begin
        if (timer_reg != 22'd0) begin
          timer_next = timer_reg - 22'd1;
        end else if (overtemp_ok_i && backdrive_ok_i) begin
          state_next = ST_TEST;
          timer_next = test_cycles - 22'd1;
        end
      end
      ST_TEST: begin
        if (timer_reg != 22'd0) begin
          timer_next = timer_reg - 22'd1;
        end else begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer state and timer
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      timer_reg <= 22'd0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
    end
  end

  // Recovery outputs; bus comparison made by analog at test voltage
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      recovery_test_current_o <= 1'b0;
      recovery_port_on_o      <= 1'b0;
      recovery_short_o        <= 1'b0;
    end else begin
      recovery_test_current_o <= (state_next == ST_TEST);
      recovery_port_on_o      <= (state_next == ST_TEST);
      recovery_short_o        <= (state_reg == ST_TEST) && (timer_reg == 22'd0)
                                 && bus_below_test_i;
    end
  end

endmodule // port_power_config_regs
`default_nettype wire

//--- include/port_power_config_map.vh
`ifndef PORT_POWER_CONFIG_MAP_VH
`define PORT_POWER_CONFIG_MAP_VH

// Register offsets
`define ADDR_PORT_CURRENT_LIMIT      8'h19
`define ADDR_REACHED_FLAG_A_THRESHOLD_HIGH   8'h1a
`define ADDR_REACHED_FLAG_A_THRESHOLD_LOW    8'h1b
`define ADDR_FAULT_RECOVERY_CONFIG   8'h1c
`define ADDR_CHARGE_CURRENT_THRESH   8'h1e
`define ADDR_DATA_SWITCH_CONFIG      8'h25

// Reset values
`define RST_PORT_CURRENT_LIMIT       3'h0
`define RST_REACHED_FLAG_A_THRESHOLD_BYTE    8'hff
`define RST_FAULT_RECOVERY_CONFIG    7'h2a
`define RST_CHARGE_CURRENT_THRESH    4'hf
`define RST_DATA_SWITCH_CONFIG       5'h14

// Data switch config field positions
`define DSW_ACCEPTED_BIT             0
`define DSW_DETECT_BIT               1
`define DSW_CDP_BIT                  2
`define DSW_CUSTOM_BIT               3

// Fault recovery config field positions
`define FRC_VOLT_LSB                 0
`define FRC_TIME_LSB                 2
`define FRC_DELAY_LSB                4

// Emulation profile codes presented by the emulation engine
`define PROFILE_NONE                 2'h0
`define PROFILE_CDP                  2'h1
`define PROFILE_CUSTOM               2'h2
`define PROFILE_DCP_LEGACY           2'h3

// Timing: cycles per millisecond at 25 MHz, sized to the 22-bit recovery timer
`define MS_CYCLES                    22'd25000

`endif

//--- test/port_power_config_chk.sv
`timescale 1ns/1ps
`default_nettype none
module port_power_config_chk (
  input wire logic        sys_clk_i,
  input wire logic        reset_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        emulation_start_i,
  input wire logic        sleep_i,
  input wire logic        total_update_i,
  input wire logic [15:0] total_charge_i,
  input wire logic        reached_flag_a_clear_i,
  input wire logic [2:0]  strap_limit_code_i,
  input wire logic [3:0]  bus_current_code_i,
  input wire logic        data_switch_close_o,
  input wire logic [2:0]  switch_current_limit_o,
  input wire logic [15:0] reached_flag_a_threshold_value_o,
  input wire logic        reached_flag_a_o,
  input wire logic        reached_flag_a_event_o,
  input wire logic [3:0]  charge_detect_current_o,
  input wire logic        emulation_success_o
);
  // Single domain, so one clocking and one disable
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_limit_below_strap: assert property (switch_current_limit_o <= strap_limit_code_i)
    else $error("limit above strap");
  a_reached_flag_a_hit_sets: assert property (total_update_i && total_charge_i >=
    reached_flag_a_threshold_value_o |=> reached_flag_a_o && reached_flag_a_event_o)
    else $error("rationing hit missed");
  a_reached_flag_a_no_hit: assert property (!(total_update_i && total_charge_i >=
    reached_flag_a_threshold_value_o) |=> !reached_flag_a_event_o)
    else $error("rationing event without hit");
  a_flag_stays_set: assert property (reached_flag_a_o && !reached_flag_a_clear_i |=> reached_flag_a_o)
    else $error("rationing flag lost");
  a_start_closes_switch: assert property (emulation_start_i |=> data_switch_close_o)
    else $error("switch open after start");
  a_success_compare: assert property (1'b1 |=> emulation_success_o ==
    ($past(bus_current_code_i) > $past(charge_detect_current_o)))
    else $error("success flag wrong");
  a_sleep_forces_thr: assert property (sleep_i |=> charge_detect_current_o == 4'hf)
    else $error("charge threshold kept in sleep");
  a_high_byte_write: assert property (reg_wr_i && reg_addr_i == 8'h1a |=>
    reached_flag_a_threshold_value_o[15:8] == $past(reg_wdata_i))
    else $error("threshold high byte not written");
endmodule // port_power_config_chk

bind port_power_config_regs port_power_config_chk chk_i (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .emulation_start_i(emulation_start_i), .sleep_i(sleep_i), .total_update_i(total_update_i),
  .total_charge_i(total_charge_i), .reached_flag_a_clear_i(reached_flag_a_clear_i),
  .strap_limit_code_i(strap_limit_code_i), .bus_current_code_i(bus_current_code_i),
  .data_switch_close_o(data_switch_close_o), .switch_current_limit_o(switch_current_limit_o),
  .reached_flag_a_threshold_value_o(reached_flag_a_threshold_value_o), .reached_flag_a_o(reached_flag_a_o),
  .reached_flag_a_event_o(reached_flag_a_event_o), .charge_detect_current_o(charge_detect_current_o),
  .emulation_success_o(emulation_success_o));
`default_nettype wire

//--- test/portable_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module portable_device_model (
  input  wire logic [3:0] draw_code_i,
  input  wire logic [3:0] lag_i,
  input  wire logic       sys_clk_i,
  output var  logic [3:0] bus_current_code_o,
  output var  logic       charging_o
);
  logic [3:0] draw_q = 4'h0;
  logic [3:0] age = 4'h0;
  // A slow device draws nothing until its lag has run out
  always @(posedge sys_clk_i) begin
    draw_q <= draw_code_i;
    age <= (draw_code_i != draw_q) ? 4'h0 : ((age >= lag_i) ? age : age + 4'h1);
    bus_current_code_o <= (age >= lag_i) ? draw_q : 4'h0;
    charging_o <= (age >= lag_i) && (draw_q != 4'h0);
  end
endmodule // portable_device_model
`default_nettype wire

//--- test/port_power_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_power_config_regs_tb;
  localparam logic [2:0] STRAP = 3'h5;
  logic        clk, rst, wr, slp, act, det, detc, start, upd, clr, err, eok, chg, close;
  logic        flag, evt, succ, tcur, pon, mflag, vshort;
  logic [1:0]  prof, tlev;
  logic [2:0]  lim;
  logic [3:0]  draw, lag, cur, ich;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] total, thr, t;
  int          n_errors, total_checks, seed, mr [256];
  logic [7:0]  amap [7] = '{8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1e, 8'h25, 8'h1d};
  logic [7:0]  rvals [7] = '{{5'h0, STRAP}, 8'hff, 8'hff, 8'h2a, 8'h0f, 8'h14, 8'h00};

  port_power_config_regs uut (.sys_clk_i(clk), .reset_i(rst), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rdata_o(rdata), .sleep_i(slp),
    .active_state_i(act), .detect_state_i(det), .detection_control_i(detc),
    .emulation_start_i(start), .emulation_profile_i(prof), .profile_accepted_i(chg),
    .charging_i(chg), .strap_limit_code_i(STRAP), .total_update_i(upd), .total_charge_i(total),
    .bus_current_code_i(cur), .error_entry_i(err), .overtemp_ok_i(eok), .backdrive_ok_i(eok),
    .bus_voltage_code_i(2'h0), .bus_below_test_i(1'b1), .reached_flag_a_clear_i(clr),
    .data_switch_close_o(close), .switch_current_limit_o(lim), .reached_flag_a_threshold_value_o(thr),
    .reached_flag_a_o(flag), .reached_flag_a_event_o(evt), .charge_detect_current_o(ich),
    .emulation_success_o(succ), .recovery_test_level_o(tlev), .recovery_test_current_o(tcur),
    .recovery_port_on_o(pon), .recovery_short_o(vshort));
  portable_device_model dev (.draw_code_i(draw), .lag_i(lag), .sys_clk_i(clk),
    .bus_current_code_o(cur), .charging_o(chg));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Model follows each write; clamp and masks mirror the register map
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge clk) wr = 1'b0;
    case (a)
      8'h19: mr[a] = (d[2:0] > STRAP) ? STRAP : d[2:0];
      8'h1a, 8'h1b: mr[a] = d;
      8'h1c: mr[a] = d & 8'h7f;
      8'h1e: if (!slp) mr[a] = d & 8'h0f;
      8'h25: mr[a] = (d & 8'h0f) | 8'h10;
      default: ;
    endcase
  endtask

  task automatic rd_chk(input logic [7:0] a);
    @(negedge clk) addr = a;
    @(negedge clk) chk(rdata, mr[a]);
  endtask

  task automatic upd_chk(input logic [15:0] v);
    @(negedge clk) {total, upd} = {v, 1'b1};
    @(negedge clk) upd = 1'b0;
    mflag = mflag | (v >= {mr[8'h1a][7:0], mr[8'h1b][7:0]});
    chk(flag, mflag);
    chk(evt, v >= {mr[8'h1a][7:0], mr[8'h1b][7:0]});
  endtask

  // Start pulse, then the profile's own switch state two cycles on
  task automatic emu(input logic [1:0] p, input logic exp_close);
    @(negedge clk) {start, prof} = {1'b1, p};
    @(negedge clk) start = 1'b0;
    chk(close, 1'b1);
    repeat (2) @(negedge clk);
    chk(close, exp_close);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Whole run is under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude;
  end

  initial begin
    {rst, wr, slp, act, det, detc, start, upd, clr, err, eok, mflag} = 12'h800;
    {prof, draw, lag, addr, wdata, total} = '0;
    seed = 32'he72ec905;
    foreach (amap[i]) mr[amap[i]] = rvals[i];
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    foreach (amap[i]) rd_chk(amap[i]);
    foreach (amap[i]) begin
      wr_reg(amap[i], 8'($random(seed)));
      rd_chk(amap[i]);
    end
    chk(tlev, mr[8'h1c] & 3);
    for (int i = 0; i < 8; i++) begin
      wr_reg(8'h19, 8'(i));
      chk(lim, (i > STRAP) ? STRAP : i);
    end
    t = {1'b0, 14'($random(seed)), 1'b1};
    wr_reg(8'h1a, t[15:8]);
    wr_reg(8'h1b, t[7:0]);
    chk(thr, t);
    upd_chk(t - 16'h1);
    upd_chk(t);
    @(negedge clk) clr = 1'b1;
    @(negedge clk) clr = 1'b0;
    chk(flag, 1'b0);
    // Clear held through the next hit: the hit must win
    @(negedge clk) clr = 1'b1;
    mflag = 1'b0;
    upd_chk(t + 16'h1);
    clr = 1'b0;
    wr_reg(8'h1e, 8'h03);
    @(negedge clk) slp = 1'b1;
    mr[8'h1e] = 8'h0f;
    wr_reg(8'h1e, 8'h05);
    foreach (amap[i]) rd_chk(amap[i]);
    @(negedge clk) slp = 1'b0;
    rd_chk(8'h1e);
    wr_reg(8'h1e, 8'($random(seed)));
    repeat (8) begin
      {draw, lag} = {4'($random(seed)), 4'($random(seed)) & 4'h3};
      repeat (8) @(negedge clk);
      chk(succ, draw > mr[8'h1e]);
    end
    {draw, act} = {4'h0, 1'b1};
    wr_reg(8'h25, 8'h00);
    emu(2'h1, 1'b0);
    wr_reg(8'h25, 8'h04);
    chk(close, 1'b0);
    emu(2'h1, 1'b1);
    wr_reg(8'h25, 8'h08);
    emu(2'h2, 1'b1);
    wr_reg(8'h25, 8'h00);
    chk(close, 1'b1);
    emu(2'h2, 1'b0);
    wr_reg(8'h25, 8'h01); // accepted-profile enable only; CDP, custom and detect enables cleared
    emu(2'h3, 1'b0);
    {draw, lag} = {4'hf, 4'h0};
    repeat (4) @(negedge clk);
    chk(close, 1'b1);
    {act, det, prof} = {1'b0, 1'b1, 2'h0};
    @(negedge clk) chk(close, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h25, {6'h0, i[1], 1'b0});
      detc = i[0];
      @(negedge clk) chk(close, i[1] & i[0]);
    end
    eok = 1'b1;
    @(negedge clk) err = 1'b1;
    @(negedge clk) err = 1'b0;
    repeat (40) @(negedge clk);
    chk({pon, tcur, vshort}, 3'h0);
    conclude;
  end
endmodule // port_power_config_regs_tb
`default_nettype wire
